// [verilog/sodc_string_operand.sv]
`timescale 1ns/1ps
module sodc_string_operand (
    input  wire logic                              clk,
    input  wire logic                              nrst,
    input  wire logic [sodc_pkg::ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [sodc_pkg::ADDR_W-1:0]       s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [31:0]                            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_neg(input logic [3:0] s);
        return (s == sodc_pkg::NEG_A) || (s == sodc_pkg::NEG_B);
    endfunction

    sodc_pkg::sodc_state_t st;
    sodc_pkg::sodc_state_t next_st;

    // ==========================================================
    // Derived control terms
    // ==========================================================
    logic        ebcdic;
    logic [3:0]  gen_plus;
    logic [3:0]  gen_minus;
    logic [3:0]  gen_zone;
    logic [3:0]  gen_sign;
    logic        delim_ok;
    logic [1:0]  src_dsg;
    logic [1:0]  res_dsg;
    logic [1:0]  act_dsg;
    logic        len_mode;
    logic        src_zero;
    logic        res_noop;
    logic        misuse;
    logic        res_undef;
    logic        append;
    logic [47:0] eff_idx;
    logic [47:0] sum_addr;

    always_comb begin
        ebcdic    = st.charset_select_bit && !st.monitor_mode;
        gen_plus  = ebcdic ? sodc_pkg::EBC_PLUS  : sodc_pkg::ASC_PLUS;
        gen_minus = ebcdic ? sodc_pkg::EBC_MINUS : sodc_pkg::ASC_MINUS;
        gen_zone  = ebcdic ? sodc_pkg::EBC_ZONE  : sodc_pkg::ASC_ZONE;
        // Move-and-scale passes the source sign through untouched.
        if (st.opcode == sodc_pkg::OP_MOVE_SCALE) begin
            gen_sign = st.dec.sign;
        end else begin
            gen_sign = st.dec.negative ? gen_minus : gen_plus;
        end
        delim_ok = (st.opcode == sodc_pkg::OP_MOVE_LEFT) || (st.opcode == sodc_pkg::OP_MOVE_LEFT_NC)
                || (st.opcode == sodc_pkg::OP_CMP_BYTES) || (st.opcode == sodc_pkg::OP_XLATE)
                || (st.opcode == sodc_pkg::OP_XLATE_TEST) || (st.opcode == sodc_pkg::OP_XLATE_MARK);
        src_dsg  = delim_ok ? st.gsub[sodc_pkg::G_SRC_MSB -: 2] : sodc_pkg::DSG_LEN;
        res_dsg  = delim_ok ? st.gsub[sodc_pkg::G_RES_MSB -: 2] : sodc_pkg::DSG_LEN;
        act_dsg  = st.field_c ? res_dsg : src_dsg;
        len_mode = (act_dsg == sodc_pkg::DSG_LEN);
        src_zero = !st.field_c && len_mode && (st.spec == 16'h0000);
        res_noop = st.field_c && len_mode && (st.spec == 16'h0000);
        // Reserved subfunction bits set on an instruction that does not own them.
        misuse   = (st.gsub[sodc_pkg::G_RSV_4] || st.gsub[sodc_pkg::G_RSV_6])
                && (st.opcode != sodc_pkg::OP_XLATE_MARK) && (st.opcode != sodc_pkg::OP_CMP_BYTES);
        res_undef = (res_dsg == sodc_pkg::DSG_MASKED);
        append    = st.field_c && (res_dsg[1] == 1'b1);
        // The top three index bits drop out of the byte shift, so negative
        // indexes still land correctly modulo the address width.
        if (st.idx_dsg == 8'h00) begin
            eff_idx = 48'h0000_0000_0000;
        end else if ((st.opcode == sodc_pkg::OP_BIT_SEARCH) || (st.opcode == sodc_pkg::OP_WORD_SEARCH)) begin
            eff_idx = st.index;
        end else begin
            eff_idx = {st.index[sodc_pkg::IDX_USED_W-1:0], 3'b000};
        end
        sum_addr = st.base + eff_idx;
    end

    // ==========================================================
    // Data byte decode and delimiter search
    // ==========================================================
    logic [7:0]          din;
    logic                din_last;
    logic                din_first;
    logic                match;
    sodc_pkg::sodc_dec_t dec_new;

    always_comb begin
        din       = st.wdata[7:0];
        din_last  = st.wdata[8];
        din_first = st.wdata[9];
        dec_new   = '0;
        case (st.fmt)
            sodc_pkg::FMT_PACKED: begin
                if (din_last) begin
                    dec_new.lo   = din[7:4];
                    dec_new.sign = din[3:0];
                end else begin
                    dec_new.hi = din[7:4];
                    dec_new.lo = din[3:0];
                end
            end
            sodc_pkg::FMT_ZONED: begin
                dec_new.lo = din[3:0];
                if (din_last) begin
                    dec_new.sign = din[7:4];
                end
            end
            sodc_pkg::FMT_BINARY: begin
                // The sign lives only in the first byte, so later bytes keep it.
                dec_new.negative = din_first ? din[7] : st.dec.negative;
            end
            default: begin
                dec_new.invalid = 1'b1;
            end
        endcase
        if (st.fmt != sodc_pkg::FMT_BINARY) begin
            dec_new.negative = is_neg(dec_new.sign);
            dec_new.invalid  = (dec_new.hi > sodc_pkg::DIGIT_MAX) || (dec_new.lo > sodc_pkg::DIGIT_MAX)
                            || (din_last && (dec_new.sign < sodc_pkg::SIGN_MIN)) || (st.fmt > sodc_pkg::FMT_BINARY);
        end
        // Result fields are never searched for their delimiter.
        match = 1'b0;
        if (!st.field_c) begin
            case (src_dsg)
                sodc_pkg::DSG_D8:     match = (din == st.spec[7:0]);
                sodc_pkg::DSG_MASKED: match = (((din ^ st.spec[7:0]) & st.spec[15:8]) == 8'h00);
                sodc_pkg::DSG_D16:    match = !din_first && st.have_prev
                                           && (st.prev == st.spec[15:8]) && (din == st.spec[7:0]);
                default:              match = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // Register read mux
    // ==========================================================
    logic [31:0] rd_val;
    logic        rd_hit;

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            sodc_pkg::OFS_CTRL:     rd_val = {st.idx_dsg, st.gsub, st.opcode, 3'b000, st.fmt, st.field_c,
                                              st.monitor_mode, st.charset_select_bit};
            sodc_pkg::OFS_BASE_LO:  rd_val = st.base[31:0];
            sodc_pkg::OFS_FIELD_HI: rd_val = {st.spec, st.base[47:32]};
            sodc_pkg::OFS_IDX_LO:   rd_val = st.index[31:0];
            sodc_pkg::OFS_IDX_HI:   rd_val = {16'h0000, st.index[47:32]};
            sodc_pkg::OFS_ADDR_LO:  rd_val = st.addr[31:0];
            sodc_pkg::OFS_ADDR_HI:  rd_val = {st.spec, st.addr[47:32]};
            sodc_pkg::OFS_DATA:     rd_val = {22'h000000, st.have_prev, 1'b0, st.prev};
            sodc_pkg::OFS_STATUS:   rd_val = {10'h000, res_undef, st.gsub[sodc_pkg::G_INC_C],
                                              st.gsub[sodc_pkg::G_INC_A], misuse, !len_mode, res_noop,
                                              src_zero, st.term, st.dec};
            sodc_pkg::OFS_GEN:      rd_val = {16'h0000, gen_sign, gen_zone, gen_minus, gen_plus};
            sodc_pkg::OFS_APPEND:   rd_val = {14'h0000, res_dsg == sodc_pkg::DSG_D16, append,
                                              (res_dsg == sodc_pkg::DSG_D16) ? st.spec : {8'h00, st.spec[7:0]}};
            default: begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Next state
    // ==========================================================
    logic        do_write;
    logic        wr_hit;
    logic [31:0] ctl_m;
    logic [31:0] idx_hi_m;

    always_comb begin
        next_st = st;
        next_st.addr = sum_addr;
        ctl_m    = merge({st.idx_dsg, st.gsub, st.opcode, 3'b000, st.fmt, st.field_c,
                          st.monitor_mode, st.charset_select_bit}, st.wdata, st.wstrb);
        idx_hi_m = merge({16'h0000, st.index[47:32]}, st.wdata, st.wstrb);
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end
        do_write = st.aw_held && st.w_held && !st.bvalid;
        wr_hit   = 1'b1;
        if (do_write) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            case (st.aw_addr)
                sodc_pkg::OFS_CTRL: begin
                    {next_st.idx_dsg, next_st.gsub, next_st.opcode, next_st.fmt, next_st.field_c,
                     next_st.monitor_mode, next_st.charset_select_bit} = {ctl_m[31:8], ctl_m[4:0]};
                end
                sodc_pkg::OFS_BASE_LO: next_st.base[31:0] = merge(st.base[31:0], st.wdata, st.wstrb);
                sodc_pkg::OFS_FIELD_HI: begin
                    {next_st.spec, next_st.base[47:32]} = merge({st.spec, st.base[47:32]}, st.wdata, st.wstrb);
                end
                sodc_pkg::OFS_IDX_LO: next_st.index[31:0] = merge(st.index[31:0], st.wdata, st.wstrb);
                sodc_pkg::OFS_IDX_HI: begin
                    next_st.index[47:32] = idx_hi_m[15:0];
                end
                sodc_pkg::OFS_DATA: begin
                    // A finished field takes no more bytes until a new first byte,
                    // and the byte that matches a delimiter never becomes an operand.
                    if (din_first || !st.term) begin
                        next_st.term = match;
                        if (!match) begin
                            next_st.dec = dec_new;
                        end
                        next_st.prev      = din;
                        next_st.have_prev = 1'b1;
                    end
                end
                default: wr_hit = 1'b0;
            endcase
            next_st.bresp = wr_hit ? sodc_pkg::RESP_OKAY : sodc_pkg::RESP_SLVERR;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready  = !next_st.w_held && !next_st.bvalid;
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = rd_val;
            next_st.rresp  = rd_hit ? sodc_pkg::RESP_OKAY : sodc_pkg::RESP_SLVERR;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        next_st.arready = !next_st.rvalid;
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st         <= '0;
            st.awready <= 1'b1;
            st.wready  <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        s_axi_awready = st.awready;
        s_axi_wready  = st.wready;
        s_axi_bvalid  = st.bvalid;
        s_axi_bresp   = st.bresp;
        s_axi_arready = st.arready;
        s_axi_rvalid  = st.rvalid;
        s_axi_rdata   = st.rdata;
        s_axi_rresp   = st.rresp;
    end

endmodule // sodc_string_operand

// [verilog/sodc_pkg.sv]
package sodc_pkg;

    // ==========================================================
    // Register map (byte addresses on the AXI4-Lite slave)
    // ==========================================================
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_BASE_LO = 8'h04;
    localparam logic [7:0] OFS_FIELD_HI = 8'h08;
    localparam logic [7:0] OFS_IDX_LO  = 8'h0C;
    localparam logic [7:0] OFS_IDX_HI  = 8'h10;
    localparam logic [7:0] OFS_ADDR_LO = 8'h14;
    localparam logic [7:0] OFS_ADDR_HI = 8'h18;
    localparam logic [7:0] OFS_DATA    = 8'h1C;
    localparam logic [7:0] OFS_STATUS  = 8'h20;
    localparam logic [7:0] OFS_GEN     = 8'h24;
    localparam logic [7:0] OFS_APPEND  = 8'h28;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Nibble codes
    // ==========================================================
    localparam logic [3:0] DIGIT_MAX   = 4'h9;
    localparam logic [3:0] SIGN_MIN    = 4'hA;
    localparam logic [3:0] NEG_A       = 4'hB;
    localparam logic [3:0] NEG_B       = 4'hD;
    localparam logic [3:0] ASC_PLUS    = 4'hA;
    localparam logic [3:0] ASC_MINUS   = 4'hB;
    localparam logic [3:0] ASC_ZONE    = 4'h3;
    localparam logic [3:0] EBC_PLUS    = 4'hC;
    localparam logic [3:0] EBC_MINUS   = 4'hD;
    localparam logic [3:0] EBC_ZONE    = 4'hF;

    // ==========================================================
    // Operation codes that change the front end's behaviour
    // ==========================================================
    localparam logic [7:0] OP_MOVE_SCALE   = 8'hFA;
    localparam logic [7:0] OP_BIT_SEARCH   = 8'hD6;
    localparam logic [7:0] OP_WORD_SEARCH  = 8'hFF;
    localparam logic [7:0] OP_MOVE_LEFT    = 8'hF8;
    localparam logic [7:0] OP_MOVE_LEFT_NC = 8'hF9;
    localparam logic [7:0] OP_CMP_BYTES    = 8'hFD;
    localparam logic [7:0] OP_XLATE        = 8'hEE;
    localparam logic [7:0] OP_XLATE_TEST   = 8'hEF;
    localparam logic [7:0] OP_XLATE_MARK   = 8'hD7;

    // ==========================================================
    // Field designators and subfunction bit positions
    // ==========================================================
    // Subfunction bit 0 is the leftmost, so bit n sits at [7-n].
    localparam int         G_SRC_MSB  = 7;
    localparam int         G_RES_MSB  = 5;
    localparam int         G_RSV_4    = 3;
    localparam int         G_INC_A    = 2;
    localparam int         G_RSV_6    = 1;
    localparam int         G_INC_C    = 0;
    localparam logic [1:0] DSG_LEN    = 2'b00;
    localparam logic [1:0] DSG_MASKED = 2'b01;
    localparam logic [1:0] DSG_D8     = 2'b10;
    localparam logic [1:0] DSG_D16    = 2'b11;

    localparam logic [1:0] FMT_PACKED = 2'd0;
    localparam logic [1:0] FMT_ZONED  = 2'd1;
    localparam logic [1:0] FMT_BINARY = 2'd2;

    localparam int         ADR_W       = 48;
    localparam int         IDX_USED_W  = 45;
    localparam int         BYTE_SHIFT  = 3;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic [3:0] hi;
        logic [3:0] lo;
        logic [3:0] sign;
        logic       negative;
        logic       invalid;
    } sodc_dec_t;

    typedef struct packed {
        logic              charset_select_bit;
        logic              monitor_mode;
        logic [7:0]        opcode;
        logic [7:0]        gsub;
        logic [7:0]        idx_dsg;
        logic              field_c;
        logic [1:0]        fmt;
        logic [ADR_W-1:0]  base;
        logic [15:0]       spec;
        logic [ADR_W-1:0]  index;
        logic [ADR_W-1:0]  addr;
        sodc_dec_t         dec;
        logic              term;
        logic              have_prev;
        logic [7:0]        prev;
        logic              aw_held;
        logic [7:0]        aw_addr;
        logic              w_held;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } sodc_state_t;

endpackage

// [testbench/sodc_string_operand_chk.sv]
`timescale 1ns/1ps
// ====================
// Register bus checks
module sodc_string_operand_chk (
    input wire logic        clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_both; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_bdone; !s_axi_bvalid ##1 s_axi_bvalid; endsequence
    a_b_timing: assert property (s_both |=> s_bdone) else $error("write answer late");
    a_r_timing: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    a_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
    a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
    a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > sodc_pkg::OFS_APPEND
        |=> s_axi_rresp == sodc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
endmodule // sodc_string_operand_chk
bind sodc_string_operand sodc_string_operand_chk i_chk (.*);

// [testbench/sodc_issue_model.sv]
`timescale 1ns/1ps
// ====================
// Issue side bus master
module sodc_issue_model (
    input  wire logic        clk,
    output logic [7:0]       s_axi_awaddr, s_axi_araddr,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
    input  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
    input  wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input  wire logic [31:0] s_axi_rdata
);
    int lag = 0;
    initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    initial {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 7'h0F;
    // Released lines carry the inverse so a late sample cannot match by luck.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_awaddr, s_axi_wdata} <= {2'h3, a, d};
        s_axi_bready <= (lag == 0);
        for (int n = 1; n > 0; n++) begin
            @(posedge clk);
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'h0, ~a};
            if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'h0, ~d};
            if (n >= lag) s_axi_bready <= 1'h1;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        {s_axi_arvalid, s_axi_araddr, s_axi_rready} <= {1'h1, a, lag == 0};
        for (int n = 1; n > 0; n++) begin
            @(posedge clk);
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'h0, ~a};
            if (n >= lag) s_axi_rready <= 1'h1;
        end
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
    endtask
endmodule // sodc_issue_model

// [testbench/sodc_string_operand_tb.sv]
`timescale 1ns/1ps
module sodc_string_operand_tb;
    logic        clk = 1'h0, nrst = 1'h0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          fails = 0, samples_checked = 0, cyc = 0;
    sodc_string_operand i_dut (.*);
    sodc_issue_model    i_host (.*);
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            complete_run;
        end
    end
    // ====================
    // Shared tasks
    // Reserved subfunction bits stay clear in every control word.
    function automatic logic [31:0] ctl(logic cs, mon, fc, logic [1:0] fm, logic [7:0] op, g, dsg);
        return {dsg, g, op, 3'h0, fm, fc, mon, cs};
    endfunction
    task automatic chk(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        i_host.wr(a, d, rr);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
        i_host.rd(a, rv, rr);
        chk(rv & m, e);
    endtask
    // ====================
    // Scenarios
    task automatic t_codes;
        logic       eb, ng;
        logic [3:0] s, pl, mi, zn;
        for (int m = 0; m < 4; m++) begin
            for (int k = 10; k < 16; k++) begin
                {s, eb} = {4'(k), m[0] && !m[1]};
                ng = (s == 4'hB) || (s == 4'hD);
                {pl, mi, zn} = eb ? 12'hCDF : 12'hAB3;
                w(sodc_pkg::OFS_CTRL, ctl(m[0], m[1], 1'h0, 2'h0, (k == 14) ? 8'hFA : 8'h00, 8'h0, 8'h0));
                w(sodc_pkg::OFS_DATA, {20'h0, 4'h3, 4'h5, s});
                rc(sodc_pkg::OFS_STATUS, 32'h3F, {26'h0, s, ng, 1'h0});
                rc(sodc_pkg::OFS_GEN, 32'hFFFF, {16'h0, (k == 14) ? s : (ng ? mi : pl), zn, mi, pl});
            end
        end
        $display("done codes");
    endtask
    task automatic t_inv;
        w(sodc_pkg::OFS_CTRL, ctl(1'h0, 1'h0, 1'h0, 2'h0, 8'h00, 8'h0, 8'h0));
        for (int i = 0; i < 3; i++) begin
            w(sodc_pkg::OFS_DATA, {22'h0, 2'h2, (i == 1) ? 8'h9A : (i == 2) ? 8'hA9 : 8'h99});
            rc(sodc_pkg::OFS_STATUS, 32'h1, {31'h0, i != 0});
        end
        $display("done invalid digits");
    endtask
    task automatic ac(input logic [7:0] op, dsg, input logic [47:0] idx, ex);
        w(sodc_pkg::OFS_CTRL, ctl(1'h0, 1'h0, 1'h0, 2'h2, op, 8'h0, dsg));
        w(sodc_pkg::OFS_IDX_LO, idx[31:0]);
        w(sodc_pkg::OFS_IDX_HI, {16'h0, idx[47:32]});
        rc(sodc_pkg::OFS_ADDR_LO, 32'hFFFFFFFF, ex[31:0]);
        rc(sodc_pkg::OFS_ADDR_HI, 32'hFFFFFFFF, {16'h0123, ex[47:32]});
    endtask
    task automatic t_addr;
        w(sodc_pkg::OFS_BASE_LO, 32'hFFFFFFF8);
        w(sodc_pkg::OFS_FIELD_HI, 32'h0123FFFF);
        ac(8'h00, 8'h01, 48'h2, 48'h8);
        ac(8'h00, 8'h01, 48'hFFFFFFFFFFFF, 48'hFFFFFFFFFFF0);
        ac(8'hD6, 8'h01, 48'h2, 48'hFFFFFFFFFFFA);
        ac(8'h00, 8'h00, 48'h2, 48'hFFFFFFFFFFF8);
        $display("done addressing");
    endtask
    task automatic dt(input logic [7:0] op, g, input logic ex);
        w(sodc_pkg::OFS_CTRL, ctl(1'h0, 1'h0, 1'h0, 2'h2, op, g, 8'h0));
        w(sodc_pkg::OFS_DATA, 32'h211);
        w(sodc_pkg::OFS_DATA, 32'h02A);
        rc(sodc_pkg::OFS_STATUS, 32'h4000, {17'h0, ex, 14'h0});
    endtask
    task automatic t_delim;
        w(sodc_pkg::OFS_FIELD_HI, 32'h002A0000);
        dt(8'hF8, 8'h80, 1'h1);
        dt(8'hD7, 8'h80, 1'h1);
        dt(8'h00, 8'h80, 1'h0);
        dt(8'hF8, 8'h00, 1'h0);
        dt(8'hF8, 8'hC0, 1'h0);
        w(sodc_pkg::OFS_FIELD_HI, 32'h112A0000);
        dt(8'hF8, 8'hC0, 1'h1);
        dt(8'hF8, 8'h40, 1'h1);
        $display("done delimiters");
    endtask
    task automatic t_fmt;
        w(sodc_pkg::OFS_CTRL, ctl(1'h1, 1'h0, 1'h0, 2'h1, 8'h00, 8'h0, 8'h0));
        w(sodc_pkg::OFS_DATA, 32'h2F7);
        rc(sodc_pkg::OFS_STATUS, 32'h3FFF, 32'h01C0);
        w(sodc_pkg::OFS_DATA, 32'h1D4);
        rc(sodc_pkg::OFS_STATUS, 32'h3FFF, 32'h0136);
        w(sodc_pkg::OFS_CTRL, ctl(1'h0, 1'h0, 1'h0, 2'h2, 8'h00, 8'h0, 8'h0));
        w(sodc_pkg::OFS_DATA, 32'h280);
        w(sodc_pkg::OFS_DATA, 32'h001);
        rc(sodc_pkg::OFS_STATUS, 32'h2, 32'h2);
        w(sodc_pkg::OFS_FIELD_HI, 32'h12340000);
        w(sodc_pkg::OFS_CTRL, ctl(1'h0, 1'h0, 1'h1, 2'h0, 8'hF8, 8'h35, 8'h0));
        rc(sodc_pkg::OFS_APPEND, 32'h3FFFF, 32'h31234);
        rc(sodc_pkg::OFS_STATUS, 32'h1A0000, 32'h1A0000);
        $display("done formats and append");
    endtask
    task automatic t_misc;
        w(sodc_pkg::OFS_FIELD_HI, 32'h0);
        w(sodc_pkg::OFS_CTRL, ctl(1'h0, 1'h0, 1'h0, 2'h0, 8'h00, 8'h0, 8'h0));
        rc(sodc_pkg::OFS_STATUS, 32'h8000, 32'h8000);
        i_host.lag = 3;
        w(sodc_pkg::OFS_CTRL, ctl(1'h0, 1'h0, 1'h1, 2'h0, 8'h00, 8'h0, 8'h0));
        rc(sodc_pkg::OFS_STATUS, 32'h10000, 32'h10000);
        i_host.lag = 0;
        i_host.wr(8'h3C, 32'h1, rr);
        chk({30'h0, rr}, {30'h0, sodc_pkg::RESP_SLVERR});
        rc(8'h3C, 32'hFFFFFFFF, 32'h0);
        chk({30'h0, rr}, {30'h0, sodc_pkg::RESP_SLVERR});
        $display("done length and bus");
    endtask
    task automatic complete_run;
        $display("compared %0d mismatched %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'h1;
        t_codes;
        t_inv;
        t_addr;
        t_delim;
        t_fmt;
        t_misc;
        complete_run;
    end
endmodule // sodc_string_operand_tb
